// ===== design/tprc_cfg.svh
// constants of the transmit peak reduction control block
// assumes inclusion by bare name from package and modules alike
`ifndef TPRC_CFG_SVH
`define TPRC_CFG_SVH

// channel and engine counts
`define TPRC_NCH 4
`define TPRC_CHW 2
`define TPRC_NENG 3
// sample component width, q1.15
`define TPRC_SW 16
// magnitude estimate width, one guard bit
`define TPRC_MW 17
// threshold value of one, full scale 0 dBFS
`define TPRC_THR_ONE 16'h8000
// correction pulse store
`define TPRC_PMEM 512
`define TPRC_PAW 9
`define TPRC_HALF_TWO 10'h100
`define TPRC_PULSE1_BASE 9'h100
`define TPRC_HLW 10
// fifo in front of the predistortion engine
`define TPRC_FIFO_W 34
`define TPRC_FIFO_D 32
`define TPRC_FIFO_LW 6
// slots kept free for samples already in the pipeline
`define TPRC_FIFO_MARGIN 6'h04

`endif

// ===== design/tprc_pkg.sv
// types of the transmit peak reduction control block
// assumes tprc_cfg.svh is on the include path
`include "tprc_cfg.svh"

package tprc_pkg;

	// one complex sample tagged with its transmit channel
	typedef struct packed {
		logic [`TPRC_CHW-1:0] chan;
		logic signed [`TPRC_SW-1:0] i;
		logic signed [`TPRC_SW-1:0] q;
	} tprc_smp_t;

	// one correction pulse coefficient
	typedef struct packed {
		logic signed [`TPRC_SW-1:0] re;
		logic signed [`TPRC_SW-1:0] im;
	} tprc_coef_t;

	// static configuration, written at initialization only
	typedef struct packed {
		logic [`TPRC_NCH-1:0][`TPRC_NENG-1:0] engineOn;
		logic [`TPRC_NCH-1:0][`TPRC_NENG-1:0] enginePassThrough;
		logic [`TPRC_NCH-1:0] clipperOn;
		logic [`TPRC_NCH-1:0][`TPRC_SW-1:0] clipThr;
		logic [`TPRC_NENG-1:0][`TPRC_SW-1:0] peakThr;
		logic pulseCorrectionModeOne;
		logic [`TPRC_HLW-1:0] pulseHalfLen;
		logic activePulse;
	} tprc_cfg_t;

	// per channel readback of the settings
	typedef struct packed {
		logic [`TPRC_NENG-1:0] engineOn;
		logic [`TPRC_NENG-1:0] enginePassThrough;
		logic clipperOn;
		logic [`TPRC_SW-1:0] clipThr;
	} tprc_rbk_t;

	// pulse readback sequencer states
	typedef enum logic [1:0] {
		RB_IDLE,
		RB_STREAM,
		RB_DONE
	} tprc_rb_t;

endpackage : tprc_pkg

// ===== design/tprc_fifo.sv
// sample fifo with a registered head word
// assumes one clock, synchronous active high reset, depth a power of two
`timescale 1ns/1ns

module tprc_fifo #(
	parameter int W = 34,
	parameter int D = 32,
	parameter int LW = 6
) (
	input wire logic core_clk,
	input wire logic rst,
	input wire logic inValid,
	output logic inReady,
	input wire logic [W-1:0] inData,
	output logic outValid,
	input wire logic outReady,
	output logic [W-1:0] outData,
	output logic [LW-1:0] level
);

	localparam int AW = $clog2(D);

	// whole state of the fifo
	typedef struct packed {
		logic [D-1:0][W-1:0] mem;
		logic [AW-1:0] wrPtr;
		logic [AW-1:0] rdPtr;
		logic [LW-1:0] count; // words in mem, head excluded
		logic headValid;
		logic [W-1:0] head;
		logic ready;
	} tprc_fifo_st_t;

	tprc_fifo_st_t st;
	tprc_fifo_st_t next_st;
	logic push;
	logic pop;

	// next state; head register keeps outData straight from a flop
	always_comb begin
		next_st = st;
		push = inValid && st.ready;
		pop = (st.count != '0) && (!st.headValid || outReady);
		if (st.headValid && outReady) begin // head taken
			next_st.headValid = 1'b0;
		end
		if (pop) begin // refill head from storage
			next_st.head = st.mem[st.rdPtr];
			next_st.headValid = 1'b1;
			next_st.rdPtr = st.rdPtr + 1'b1;
		end
		if (push) begin // store new word
			next_st.mem[st.wrPtr] = inData;
			next_st.wrPtr = st.wrPtr + 1'b1;
		end
		next_st.count = st.count + LW'(push) - LW'(pop);
		// ready is honest: computed from the count it will see
		next_st.ready = next_st.count < LW'(D);
	end

	// state register
	always_ff @(posedge core_clk) begin
		if (rst) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign inReady = st.ready;
	assign outValid = st.headValid;
	assign outData = st.head;
	assign level = st.count;

endmodule : tprc_fifo

// ===== design/tprc_top.sv
// transmit peak reduction control: engines, hard clipper, pulse store
// assumes config is static after init and comes from core_clk logic
`timescale 1ns/1ns
`include "tprc_cfg.svh"

// Behaviour
// - on and not pass-through: correct samples
// - on and pass-through: samples go around unchanged
// - off: engine fully disabled, pass-through ignored
// - engines sit before the predistortion output
// - per channel readback of on, pass-through
// - clip when magnitude estimate exceeds threshold
// - threshold normalized, one equals full scale
// - readback two pulses of 256, or one 512
// - report number of pulses actually returned
// - stored pulse used only in mode one
// - per channel clipper on enables, off disables
module tprc_top (
	input wire logic core_clk,
	input wire logic rst,
	input wire tprc_pkg::tprc_cfg_t cfg,
	input wire tprc_pkg::tprc_smp_t smpIn,
	input wire logic smpInValid,
	output logic smpInReady,
	output tprc_pkg::tprc_smp_t smpOut,
	output logic smpOutValid,
	input wire logic smpOutReady,
	output logic [`TPRC_NCH-1:0] engineActive,
	input wire logic [`TPRC_CHW-1:0] cfgRbChan,
	output tprc_pkg::tprc_rbk_t cfgRb,
	input wire logic coefWrEn,
	input wire logic [`TPRC_PAW-1:0] coefWrAddr,
	input wire tprc_pkg::tprc_coef_t coefWr,
	input wire logic rbReq,
	input wire logic [1:0] rbMax,
	output logic rbCoefValid,
	output tprc_pkg::tprc_coef_t rbCoef,
	output logic [`TPRC_PAW-1:0] rbCoefAddr,
	output logic rbDone,
	output logic [1:0] rbNumReturned
);
	import tprc_pkg::*;

	// whole state of the block
	// the pulse store sits in the state too, so reset clears it
	typedef struct packed {
		logic [`TPRC_PMEM-1:0][2*`TPRC_SW-1:0] pmem; // correction pulse store
		logic aValid; // engine stage
		tprc_smp_t aSmp;
		logic bValid; // clipper stage
		tprc_smp_t bSmp;
		logic inReady;
		logic [`TPRC_NCH-1:0] active;
		tprc_rbk_t rbk;
		tprc_rb_t rbState;
		logic rbPulse; // pulse being streamed
		logic [`TPRC_PAW-1:0] rbIdx; // index within that pulse
		logic [1:0] rbNum;
		logic rbValid;
		tprc_coef_t rbData;
		logic [`TPRC_PAW-1:0] rbAddr;
		logic rbDoneP;
		logic [1:0] rbNumOut;
	} tprc_st_t;

	tprc_st_t st;
	tprc_st_t next_st;

	// fifo handshake wires
	// fifoLevel counts stored words only; the head word is not in it
	logic fifoInReady;
	logic [`TPRC_FIFO_LW-1:0] fifoLevel;
	logic [`TPRC_FIFO_W-1:0] fifoOut;

	// magnitude estimate, max plus half of min, fixed for this design
	// never below the true root and at most about 12 percent above it,
	// so the clipper may pull a sample slightly further than needed
	function automatic logic [`TPRC_MW-1:0] magEst(
		input logic signed [`TPRC_SW-1:0] i,
		input logic signed [`TPRC_SW-1:0] q
	);
		logic [`TPRC_MW-1:0] ai;
		logic [`TPRC_MW-1:0] aq;
		ai = i[`TPRC_SW-1] ? `TPRC_MW'(-{i[`TPRC_SW-1], i}) : `TPRC_MW'(i);
		aq = q[`TPRC_SW-1] ? `TPRC_MW'(-{q[`TPRC_SW-1], q}) : `TPRC_MW'(q);
		if (ai >= aq) begin
			magEst = ai + (aq >> 1);
		end else begin
			magEst = aq + (ai >> 1);
		end
	endfunction : magEst

	// scale a component by an unsigned q1.15 gain
	// result truncates toward minus infinity; a gain of 16'h8000 is unity
	function automatic logic signed [`TPRC_SW-1:0] scaleBy(
		input logic signed [`TPRC_SW-1:0] x,
		input logic [`TPRC_SW-1:0] g
	);
		logic signed [2*`TPRC_SW:0] prod;
		prod = x * $signed({1'b0, g});
		scaleBy = prod[2*`TPRC_SW-2:`TPRC_SW-1];
	endfunction : scaleBy

	// number of pulses the store holds for the programmed half length
	// a half length above 256 fills both halves of the store
	function automatic logic [1:0] pulsesStored(input logic [`TPRC_HLW-1:0] hl);
		if (hl == '0) begin
			pulsesStored = 2'h0;
		end else if (hl <= `TPRC_HALF_TWO) begin
			pulsesStored = 2'h2;
		end else begin
			pulsesStored = 2'h1;
		end
	endfunction : pulsesStored

	// helper values of the combinational process
	logic [`TPRC_PAW-1:0] ctrIdx;
	tprc_coef_t ctrCoef;
	tprc_smp_t engSmp;
	logic [`TPRC_MW-1:0] mag;
	logic [`TPRC_MW-1:0] cmag;
	logic [`TPRC_SW-1:0] cthr;
	logic [2*`TPRC_SW-1:0] gainWide;
	logic [`TPRC_SW-1:0] gain;
	logic [1:0] stored;
	logic [1:0] want;
	logic [`TPRC_PAW-1:0] lastIdx;
	logic [`TPRC_FIFO_LW:0] fifoFill; // level plus margin, one bit wider

	// next state of the whole block
	always_comb begin
		next_st = st;
		stored = pulsesStored(cfg.pulseHalfLen);
		// peak of the active half pulse is its last coefficient
		// the second pulse exists only while two pulses fit in the store
		ctrIdx = `TPRC_PAW'(cfg.pulseHalfLen - 1'b1);
		if (cfg.activePulse && stored == 2'h2) begin
			ctrIdx = ctrIdx + `TPRC_PULSE1_BASE;
		end
		ctrCoef = st.pmem[ctrIdx];
		lastIdx = `TPRC_PAW'(cfg.pulseHalfLen - 1'b1);

		// coefficient writes into the pulse store
		// a write lands in the store one cycle later, shared by all channels
		if (coefWrEn) begin
			next_st.pmem[coefWrAddr] = coefWr;
		end

		// engine stage, runs ahead of the clipper and the output fifo
		// engines act in order 0, 1, 2, each on the result of the one before
		next_st.aValid = smpInValid && st.inReady;
		engSmp = smpIn;
		for (int e = 0; e < `TPRC_NENG; e++) begin
			mag = magEst(engSmp.i, engSmp.q);
			if (!cfg.engineOn[smpIn.chan][e]) begin
				// engine off: nothing touches the sample
				engSmp = engSmp;
			end else if (cfg.enginePassThrough[smpIn.chan][e]) begin
				// routed around the engine unmodified
				engSmp = engSmp;
			end else if (mag > `TPRC_MW'(cfg.peakThr[e])) begin
				// peak above this engine's threshold: pull the sample in
				if (cfg.pulseCorrectionModeOne) begin
					// stored pulse peak weights the correction
					engSmp.i = scaleBy(engSmp.i, ctrCoef.re[`TPRC_SW-1:0]);
					engSmp.q = scaleBy(engSmp.q, ctrCoef.re[`TPRC_SW-1:0]);
				end else begin
					// other modes: fixed three quarter pull-in
					engSmp.i = engSmp.i - (engSmp.i >>> 2);
					engSmp.q = engSmp.q - (engSmp.q >>> 2);
				end
			end
		end
		next_st.aSmp = engSmp;

		// hard clipper stage on the estimate of sqrt(i*i + q*q)
		next_st.bValid = st.aValid;
		next_st.bSmp = st.aSmp;
		cthr = cfg.clipThr[st.aSmp.chan]; // 16'h8000 is full scale
		cmag = magEst(st.aSmp.i, st.aSmp.q);
		// divider is combinational; trade of area for zero stall
		gainWide = (cmag == '0) ? '0 : 32'({cthr, 15'h0000} / 31'(cmag));
		// quotient stays below 16'h8000 whenever the clip branch is taken
		gain = gainWide[`TPRC_SW-1:0];
		// samples at or below the threshold pass untouched
		if (cfg.clipperOn[st.aSmp.chan] && cmag > `TPRC_MW'(cthr)) begin
			next_st.bSmp.i = scaleBy(st.aSmp.i, gain);
			next_st.bSmp.q = scaleBy(st.aSmp.q, gain);
		end

		// keep room for samples still in flight; fifo full stalls input
		// the sum is one bit wider, a level near full must not wrap to small
		fifoFill = {1'b0, fifoLevel} + {1'b0, `TPRC_FIFO_MARGIN};
		next_st.inReady = fifoInReady && (fifoFill <= (`TPRC_FIFO_LW+1)'(`TPRC_FIFO_D));

		// per channel engine state and settings readback
		// both follow cfg one cycle late, as plain registers
		for (int c = 0; c < `TPRC_NCH; c++) begin
			next_st.active[c] = |(cfg.engineOn[c] & ~cfg.enginePassThrough[c]);
		end
		next_st.rbk.engineOn = cfg.engineOn[cfgRbChan];
		next_st.rbk.enginePassThrough = cfg.enginePassThrough[cfgRbChan];
		next_st.rbk.clipperOn = cfg.clipperOn[cfgRbChan];
		next_st.rbk.clipThr = cfg.clipThr[cfgRbChan];

		// pulse readback sequencer
		// one word per cycle; the reader cannot stall it, so it must keep up
		next_st.rbValid = 1'b0;
		next_st.rbDoneP = 1'b0;
		want = (rbMax > 2'h2) ? 2'h2 : rbMax;
		case (st.rbState)
			RB_IDLE: begin
				// requests while streaming are ignored; only idle takes one
				if (rbReq) begin
					// fewer than asked when fewer are stored
					next_st.rbNum = (want < stored) ? want : stored;
					next_st.rbPulse = 1'b0;
					next_st.rbIdx = '0;
					if (want == 2'h0 || stored == 2'h0) begin
						next_st.rbState = RB_DONE;
					end else begin
						next_st.rbState = RB_STREAM;
					end
				end
			end
			RB_STREAM: begin
				// word out every cycle; pulse one sits in the upper half of the store
				next_st.rbValid = 1'b1;
				next_st.rbAddr = st.rbPulse ? (st.rbIdx + `TPRC_PULSE1_BASE) : st.rbIdx;
				next_st.rbData = st.pmem[next_st.rbAddr];
				next_st.rbIdx = st.rbIdx + 1'b1;
				if (st.rbIdx == lastIdx) begin
					next_st.rbIdx = '0;
					if (!st.rbPulse && st.rbNum == 2'h2) begin
						next_st.rbPulse = 1'b1; // second pulse follows
					end else begin
						next_st.rbState = RB_DONE;
					end
				end
			end
			RB_DONE: begin
				// count stays on its port until the next readback ends
				next_st.rbDoneP = 1'b1;
				next_st.rbNumOut = st.rbNum;
				next_st.rbState = RB_IDLE;
			end
			default: begin
				// unreachable encoding, fall back to idle
				next_st.rbState = RB_IDLE;
			end
		endcase
	end

	// state register
	// synchronous reset clears the pulse store along with everything else
	always_ff @(posedge core_clk) begin
		if (rst) begin
			st <= '0;
			st.rbState <= RB_IDLE;
		end else begin
			st <= next_st;
		end
	end

	// output fifo toward the predistortion engine
	// it rides out stalls of the far side; words are never dropped because
	// the input stops while the fifo still has room for the pipeline
	tprc_fifo #(
		.W(`TPRC_FIFO_W),
		.D(`TPRC_FIFO_D),
		.LW(`TPRC_FIFO_LW)
	) outFifo (
		.core_clk(core_clk),
		.rst(rst),
		.inValid(st.bValid),
		.inReady(fifoInReady),
		.inData(st.bSmp),
		.outValid(smpOutValid),
		.outReady(smpOutReady),
		.outData(fifoOut),
		.level(fifoLevel)
	);

	// outputs straight from state flops
	// smpOut and smpOutValid come from the fifo's own head register
	assign smpOut = fifoOut;
	assign smpInReady = st.inReady;
	assign engineActive = st.active;
	assign cfgRb = st.rbk;
	assign rbCoefValid = st.rbValid;
	assign rbCoef = st.rbData;
	assign rbCoefAddr = st.rbAddr;
	assign rbDone = st.rbDoneP;
	assign rbNumReturned = st.rbNumOut;

endmodule : tprc_top

// ===== sim/tprc_top_props.sv
// checker for the peak reduction top: stream, readback and clipper relations
// assumes one clock, synchronous reset, bound onto tprc_top
`timescale 1ns/1ns
`include "tprc_cfg.svh"
module tprc_top_props (
	input wire logic core_clk,
	input wire logic rst,
	input wire tprc_pkg::tprc_cfg_t cfg,
	input wire tprc_pkg::tprc_smp_t smpOut,
	input wire logic smpOutValid,
	input wire logic smpOutReady,
	input wire logic [`TPRC_NCH-1:0] engineActive,
	input wire logic [`TPRC_CHW-1:0] cfgRbChan,
	input wire tprc_pkg::tprc_rbk_t cfgRb,
	input wire logic rbReq,
	input wire logic [1:0] rbMax,
	input wire logic rbCoefValid,
	input wire logic [`TPRC_PAW-1:0] rbCoefAddr,
	input wire logic rbDone,
	input wire logic [1:0] rbNumReturned
);
	import tprc_pkg::*;
	logic busy; // readback in flight, requests then ignored
	logic [`TPRC_NCH-1:0] act; // channels with a correcting engine
	tprc_rbk_t rbExp; // settings of the selected channel
	// expected flags and readback, pure functions of config
	always_comb begin
		for (int c = 0; c < `TPRC_NCH; c++) act[c] = |(cfg.engineOn[c] & ~cfg.enginePassThrough[c]);
		rbExp = {cfg.engineOn[cfgRbChan], cfg.enginePassThrough[cfgRbChan], cfg.clipperOn[cfgRbChan],
			cfg.clipThr[cfgRbChan]};
	end
	// track the readback sequencer from outside
	always_ff @(posedge core_clk) begin
		busy <= rst ? 1'b0 : (busy ? !rbDone : rbReq);
	end
	// max plus half min, 17 bits so full scale negative fits
	function automatic logic [16:0] mag(tprc_smp_t s);
		logic [16:0] a;
		logic [16:0] b;
		a = s.i[15] ? -{s.i[15], s.i} : {1'b0, s.i};
		b = s.q[15] ? -{s.q[15], s.q} : {1'b0, s.q};
		return (a > b) ? a + (b >> 1) : b + (a >> 1);
	endfunction : mag
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (rst);
	sequence rbStart;
		rbReq && !busy;
	endsequence
	chk_active_flags: assert property (!$past(rst) |-> engineActive == $past(act))
		else $error("engine active flags wrong");
	chk_cfg_readback: assert property (!$past(rst) |-> cfgRb == $past(rbExp))
		else $error("config readback wrong");
	chk_out_hold: assert property (smpOutValid && !smpOutReady |=> smpOutValid && $stable(smpOut))
		else $error("output sample not held");
	chk_clip_bound: assert property (smpOutValid && cfg.clipperOn[smpOut.chan] |->
		mag(smpOut) <= {1'b0, cfg.clipThr[smpOut.chan]} + 17'h00002)
		else $error("clipped sample above threshold");
	chk_done_pulse: assert property (rbDone |=> !rbDone)
		else $error("done longer than one cycle");
	chk_num_limit: assert property (rbDone |-> rbNumReturned <= (cfg.pulseHalfLen > 10'h100 ? 2'h1 : 2'h2))
		else $error("too many pulses reported");
	chk_zero_read: assert property (rbStart ##0 rbMax == 2'h0 |-> ##2 rbDone && rbNumReturned == 2'h0)
		else $error("empty readback not reported");
	chk_first_word: assert property (rbStart ##0 rbMax != 2'h0 && cfg.pulseHalfLen != 10'h000 |->
		##2 rbCoefValid && rbCoefAddr == 9'h000)
		else $error("first readback word missing");
	chk_addr_step: assert property (rbCoefValid && $past(rbCoefValid) && rbCoefAddr != 9'h100 |->
		rbCoefAddr == $past(rbCoefAddr) + 9'h001)
		else $error("readback address skipped");
endmodule : tprc_top_props

bind tprc_top tprc_top_props chk (.core_clk, .rst, .cfg, .smpOut, .smpOutValid, .smpOutReady, .engineActive,
	.cfgRbChan, .cfgRb, .rbReq, .rbMax, .rbCoefValid, .rbCoefAddr, .rbDone, .rbNumReturned);

// ===== sim/tprc_sink.sv
// sink standing in for the predistortion input
// assumes the bench drives stall after the falling edge
`timescale 1ns/1ns
module tprc_sink (
	input wire logic core_clk,
	input wire logic rst,
	input wire logic stall,
	input wire tprc_pkg::tprc_smp_t smpOut,
	input wire logic smpOutValid,
	output logic smpOutReady
);
	import tprc_pkg::*;
	tprc_smp_t got[$]; // accepted samples in arrival order
	initial smpOutReady = 1'b0;
	// ready moves only at the falling edge, away from sampling
	always @(negedge core_clk) smpOutReady <= !stall && !rst;
	// whole samples are taken at the handshake edge
	always @(posedge core_clk) if (!rst && smpOutValid && smpOutReady) got.push_back(smpOut);
endmodule : tprc_sink

// ===== sim/tb.sv
// bench for the peak reduction top with a stalling sink
// assumes the design, package and sink are compiled before it
`timescale 1ns/1ns
`include "tprc_cfg.svh"
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin n_fail++; $display("ERROR %0t: got %0h exp %0h", $time, a, b); end end
module tb;
	import tprc_pkg::*;
	logic core_clk = 1'b0;
	logic rst = 1'b1;
	logic stall = 1'b1; // sink holds off while high
	tprc_cfg_t cfg;
	tprc_smp_t smpIn = '0;
	logic smpInValid = 1'b0;
	logic smpInReady, smpOutValid, smpOutReady, rbCoefValid, rbDone;
	tprc_smp_t smpOut;
	logic [3:0] engineActive;
	logic [1:0] cfgRbChan = 2'h0;
	tprc_rbk_t cfgRb;
	logic coefWrEn = 1'b0;
	logic [8:0] coefWrAddr = 9'h000;
	tprc_coef_t coefWr = '0;
	logic rbReq = 1'b0;
	logic [1:0] rbMax = 2'h0;
	tprc_coef_t rbCoef;
	logic [8:0] rbCoefAddr;
	logic [1:0] rbNumReturned;
	tprc_smp_t exp[$]; // expected samples in order
	int n_fail = 0;
	int n_tests = 0;
	int n;
	tprc_top uut (.core_clk, .rst, .cfg, .smpIn, .smpInValid, .smpInReady, .smpOut, .smpOutValid, .smpOutReady,
		.engineActive, .cfgRbChan, .cfgRb, .coefWrEn, .coefWrAddr, .coefWr, .rbReq, .rbMax, .rbCoefValid, .rbCoef,
		.rbCoefAddr, .rbDone, .rbNumReturned);
	tprc_sink sink (.core_clk, .rst, .stall, .smpOut, .smpOutValid, .smpOutReady);
	// free running clock
	initial begin
		forever #2 core_clk = ~core_clk;
	end
	task automatic results();
		$display("checks %0d mismatches %0d", n_tests, n_fail);
		if (n_fail == 0 && n_tests > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask : results
	task automatic tmo();
		n_fail++;
		$display("ERROR %0t: wait ran out", $time);
		results();
	endtask : tmo
	// queue the expected form of one sample, then hold it until ready is seen
	task automatic push(input logic [1:0] c, input logic [15:0] i, q, ei, eq);
		int k;
		smpIn = '{c, i, q};
		smpInValid = 1'b1;
		exp.push_back('{c, ei, eq});
		for (k = 0; k < 40 && smpInReady !== 1'b1; k++) @(negedge core_clk);
		if (k == 40) tmo();
		@(negedge core_clk);
	endtask : push
	// release the sink and compare everything that arrives
	task automatic drain();
		int k;
		smpInValid = 1'b0;
		stall = 1'b0;
		for (k = 0; k < 300 && sink.got.size() < exp.size(); k++) @(negedge core_clk);
		if (k == 300) tmo();
		foreach (exp[j]) `CHK(sink.got[j], exp[j])
		sink.got.delete();
		exp.delete();
	endtask : drain
	// one pulse readback; words carry re = addr<<6, im = ~addr
	task automatic rd(input logic [1:0] m, input int words, input logic [1:0] nr);
		int k;
		int w;
		logic [8:0] ea; // expected store address of the next word
		w = 0;
		rbMax = m;
		rbReq = 1'b1;
		@(negedge core_clk);
		rbReq = 1'b0;
		for (k = 0; k < 700 && rbDone !== 1'b1; k++) begin
			@(negedge core_clk);
			if (rbCoefValid === 1'b1) begin
				// pulse zero from 0, pulse one from 256, halfLen words each
				ea = (w < int'(cfg.pulseHalfLen)) ? 9'(w) : 9'(w) + 9'h100 - 9'(cfg.pulseHalfLen);
				w++;
				`CHK(rbCoefAddr, ea)
				`CHK(rbCoef, {1'b0, ea, 6'h00, ~{7'h00, ea}})
			end
		end
		if (k == 700) tmo();
		`CHK(rbNumReturned, nr)
		`CHK(w, words)
		@(negedge core_clk);
	endtask : rd
	// main sequence: config during reset, then traffic and readback
	initial begin
		cfg = '0;
		cfg.engineOn = {3'b000, 3'b001, 3'b111, 3'b000};
		cfg.enginePassThrough = {3'b000, 3'b000, 3'b111, 3'b111};
		cfg.clipperOn = 4'b1000;
		cfg.clipThr = {4{16'h4000}};
		cfg.peakThr = {16'h7fff, 16'h7fff, 16'h1000};
		cfg.pulseHalfLen = 10'h002;
		repeat (6) @(negedge core_clk);
		`CHK(smpOutValid, 1'b0)
		rst = 1'b0;
		repeat (2) @(negedge core_clk);
		`CHK(engineActive, 4'b0100)
		for (int c = 0; c < 4; c++) begin
			cfgRbChan = 2'(c);
			@(negedge core_clk);
			`CHK(cfgRb, {cfg.engineOn[c], cfg.enginePassThrough[c], cfg.clipperOn[c], cfg.clipThr[c]})
		end
		// back to back, sink stalled first
		push(2'h0, 16'h6000, 16'h9000, 16'h6000, 16'h9000);
		push(2'h1, 16'h6000, 16'h9000, 16'h6000, 16'h9000);
		push(2'h2, 16'h2000, 16'h0000, 16'h1800, 16'h0000);
		push(2'h3, 16'h6000, 16'h0000, 16'h3fff, 16'h0000);
		smpInValid = 1'b0;
		repeat (10) @(negedge core_clk);
		drain();
		// fill against a stalled sink until refused
		stall = 1'b1;
		n = 0;
		for (int k = 0; k < 60; k++) begin
			smpIn = '{2'h0, 16'(k), 16'h0000};
			smpInValid = 1'b1;
			if (smpInReady === 1'b1) begin
				exp.push_back(smpIn);
				n++;
			end
			@(negedge core_clk);
		end
		smpInValid = 1'b0;
		// one word in the head plus 32 stored, the margin covers the pipeline
		`CHK(n, 33)
		`CHK(smpInReady, 1'b0)
		drain();
		// store coefficients with traffic stopped
		for (int a = 0; a < 300; a++) begin
			coefWrEn = 1'b1;
			coefWrAddr = 9'(a);
			coefWr = {16'(a) << 6, ~16'(a)};
			@(negedge core_clk);
		end
		coefWrEn = 1'b0;
		@(negedge core_clk);
		rd(2'h3, 4, 2'h2);
		rd(2'h1, 2, 2'h1);
		rd(2'h0, 0, 2'h0);
		cfg.pulseHalfLen = 10'h12c;
		rd(2'h2, 300, 2'h1);
		cfg.pulseHalfLen = 10'h002;
		cfg.pulseCorrectionModeOne = 1'b1;
		@(negedge core_clk);
		push(2'h2, 16'h2000, 16'h0000, 16'h0010, 16'h0000);
		drain();
		// second stored pulse: its peak at 256 + halfLen - 1 weights the sample
		cfg.activePulse = 1'b1;
		@(negedge core_clk);
		push(2'h2, 16'h2000, 16'h0000, 16'h1010, 16'h0000);
		drain();
		results();
	end
endmodule : tb
